// File: bench/fault_status_registers_assertions.sv
// Port-level checker for the fault status bank.
// Assumes one clock domain; clk_en low freezes all state.
`timescale 1ns/1ps
module fsr_checker (
   // Clock and control
   input wire logic       sys_clk,
   input wire logic       srst,
   input wire logic       clk_en,
   // Register port
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   // Detectors and alert
   input wire logic       step_down_mode,
   input wire logic       low_voltage_bus_out_uv,
   input wire logic       low_voltage_bus_in_ov,
   input wire logic       high_voltage_bus_out_uv,
   input wire logic       controller_supply_input_ov,
   input wire logic       driver_supply_not_good,
   input wire logic       alert_pin_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Flag sets at the detector edge, the pin follows one edge later
   AST_STEP_DOWN_WARN: assert property (clk_en && step_down_mode && low_voltage_bus_out_uv
      ##1 clk_en |=> !alert_pin_n) else $error("no alert after step-down warning");
   AST_STEP_UP_WARN: assert property (clk_en && !step_down_mode
      && (low_voltage_bus_in_ov || high_voltage_bus_out_uv) ##1 clk_en |=> !alert_pin_n)
      else $error("no alert after step-up warning");
   AST_SUPPLY_OV: assert property (controller_supply_input_ov && clk_en ##1 clk_en
      |-> ##1 !alert_pin_n) else $error("no alert after supply overvoltage");
   AST_REG_FAULT: assert property (driver_supply_not_good && clk_en ##0 clk_en [*2]
      |=> !alert_pin_n) else $error("no alert after regulator fault");
   AST_RD_ANSWER: assert property (reg_rd && !reg_wr && clk_en |=> reg_rvalid)
      else $error("read not answered");
   AST_RVALID_CAUSE: assert property (reg_rvalid && $past(clk_en)
      |-> $past(reg_rd) && !$past(reg_wr)) else $error("answer without read");
   AST_RSVD_ZERO: assert property (reg_rvalid && $past(clk_en) && $past(reg_addr) == 8'hd4
      |-> (reg_rdata & 8'hce) == 8'h00) else $error("reserved regulator bit set");
   AST_SUMMARY: assert property (reg_rvalid && $past(clk_en) && $past(reg_addr) == 8'hc0
      |-> reg_rdata[6:3] == 4'h0 && reg_rdata[7] == |reg_rdata[2:0])
      else $error("summary byte inconsistent");
   // Without a write nothing may clear a flag
   AST_STICKY: assert property (!alert_pin_n && !reg_wr && !$past(reg_wr)
      |-> ##2 !alert_pin_n) else $error("alert dropped without write");
   AST_RESET: assert property (disable iff (1'b0) srst && clk_en
      |=> alert_pin_n && !reg_rvalid) else $error("reset state wrong");
endmodule
bind fault_status_registers fsr_checker chk (.*);

// File: bench/fault_status_registers_tb.sv
// Self-checking bench for the fault status bank.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
module fault_status_registers_tb;
   import fault_status_pkg::*;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic        clk_en = 1'b1;
   logic        step_down_mode = 1'b1;
   logic [18:0] det = 19'h0;
   logic        reg_wr;
   logic        reg_rd;
   logic        reg_rvalid;
   logic        alert_pin_n;
   fault_byte_t reg_addr;
   fault_byte_t reg_wdata;
   fault_byte_t reg_rdata;
   int          failures = 0;
   int          cmp_count = 0;
   // 4 ns clock
   always #2 sys_clk = ~sys_clk;
   host_mcu_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   // Detector bits 0-7 bus warnings, 8-15 auxiliary, 16-18 regulator
   fault_status_registers uut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .step_down_mode(step_down_mode),
      .low_voltage_bus_out_ov(det[0]), .low_voltage_bus_out_uv(det[1]),
      .low_voltage_bus_in_ov(det[2]), .low_voltage_bus_in_uv(det[3]),
      .high_voltage_bus_out_ov(det[4]), .high_voltage_bus_out_uv(det[5]),
      .high_voltage_bus_in_ov(det[6]), .high_voltage_bus_in_uv(det[7]),
      .six_volt_aux_rail_ov(det[8]), .six_volt_aux_rail_uv(det[9]),
      .twelve_volt_driver_rail_ov(det[10]), .twelve_volt_driver_rail_uv(det[11]),
      .flyback_overcurrent(det[12]), .controller_supply_input_ov(det[13]),
      .low_voltage_bus_supply_lockout(det[14]), .power_on_reset_event(det[15]),
      .driver_supply_not_good(det[16]), .aux_regulator_output_ov(det[17]),
      .aux_regulator_output_uv(det[18]), .alert_pin_n(alert_pin_n));
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input fault_byte_t exp, input fault_byte_t got);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // A missing answer ends the run at once
   task automatic rd_chk(input fault_byte_t a, input fault_byte_t exp);
      fault_byte_t d;
      bit          ok;
      host.rd(a, d, ok);
      chk("rvalid", 8'h01, {7'h0, ok});
      if (!ok)
         tally_and_finish();
      chk($sformatf("reg %h", a), exp, d);
   endtask
   // Pulse one detector, then read, write ones, clear with zero
   task automatic flag_case(input int idx, input logic mode, input fault_byte_t a,
                            input fault_byte_t exp);
      @(posedge sys_clk);
      step_down_mode <= mode;
      det[idx] <= 1'b1;
      @(posedge sys_clk);
      det[idx] <= 1'b0;
      rd_chk(a, exp);
      if (exp != 8'h00)
      begin
         chk("alert_pin_n", 8'h00, {7'h0, alert_pin_n});
         rd_chk(8'hc0, 8'h80 | ((a == 8'hd2) ? 8'h01 : (a == 8'hd3) ? 8'h02 : 8'h04));
         host.wr(a, 8'hff);
         rd_chk(a, exp);
         host.wr(a, ~exp);
         rd_chk(a, 8'h00);
         chk("alert_pin_n", 8'h01, {7'h0, alert_pin_n});
      end
   endtask
   task automatic test_por();
      rd_chk(8'hd3, 8'h80);
      rd_chk(8'hd2, 8'h00);
      rd_chk(8'hd4, 8'h00);
      rd_chk(8'hc0, 8'h82);
      host.por_service();
      rd_chk(8'hd3, 8'h00);
      host.wr(8'hc0, 8'hff);
      rd_chk(8'hc0, 8'h00);
      rd_chk(8'h10, 8'h00);
      $display("test por done");
   endtask
   // Step-down flags are bits 0, 1, 6 and 7
   task automatic test_flags();
      for (int i = 0; i < 16; i++)
         flag_case(i % 8, i >= 8, 8'hd2,
                   ((8'hc3 >> (i % 8)) % 2 == (i >= 8)) ? 8'h01 << (i % 8) : 8'h00);
      for (int i = 0; i < 8; i++)
         flag_case(8 + i, 1'b1, 8'hd3, 8'h01 << i);
      for (int i = 0; i < 3; i++)
         flag_case(16 + i, 1'b1, 8'hd4, 8'h01 << (i == 0 ? 0 : i + 3));
      $display("test flags done");
   endtask
   // A detector firing in the clear cycle keeps its flag
   task automatic test_set_wins();
      fork
         host.wr(8'hd3, 8'h00);
         begin
            @(posedge sys_clk);
            det[12] <= 1'b1;
            @(posedge sys_clk);
            det[12] <= 1'b0;
         end
      join
      rd_chk(8'hd3, 8'h10);
      chk("alert_pin_n", 8'h00, {7'h0, alert_pin_n});
      host.wr(8'hd3, 8'h00);
      rd_chk(8'hd3, 8'h00);
      $display("test set wins done");
   endtask
   // With the enable low a detector pulse leaves no flag
   task automatic test_freeze();
      @(posedge sys_clk);
      clk_en <= 1'b0;
      det[8] <= 1'b1;
      @(posedge sys_clk);
      det[8] <= 1'b0;
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd_chk(8'hd3, 8'h00);
      chk("alert_pin_n", 8'h01, {7'h0, alert_pin_n});
      $display("test freeze done");
   endtask
   // A second reset clears flags and raises the power-on flag again
   task automatic test_reset_again();
      @(posedge sys_clk);
      det[16] <= 1'b1;
      @(posedge sys_clk);
      det[16] <= 1'b0;
      srst <= 1'b1;
      @(posedge sys_clk);
      srst <= 1'b0;
      rd_chk(8'hd3, 8'h80);
      chk("alert_pin_n", 8'h00, {7'h0, alert_pin_n});
      rd_chk(8'hd4, 8'h00);
      host.por_service();
      rd_chk(8'hd3, 8'h00);
      $display("test reset again done");
   endtask
   initial
   begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      test_por();
      test_flags();
      test_set_wins();
      test_freeze();
      test_reset_again();
      tally_and_finish();
   end
endmodule

// File: bench/host_mcu_model.sv
// Host microcontroller model on the register port.
// Assumes single-cycle strobes and a read answer one edge after the strobe.
`timescale 1ns/1ps
module host_mcu_model (
   // Clock
   input  wire logic       sys_clk,
   // Register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   // Idle port
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Released lines are inverted so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // Bounded wait for the answer
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      for (int i = 0; i < 3 && !ok; i++)
      begin
         #1;
         if (reg_rvalid === 1'b1)
         begin
            ok = 1'b1;
            d = reg_rdata;
         end
         else
            @(posedge sys_clk);
      end
   endtask
   task automatic por_service();
      logic [7:0] d;
      bit         ok;
      rd(8'hd3, d, ok);
      // Control reload happens here, before the flag is dropped
      if (ok && d[7] === 1'b1)
         wr(8'hd3, 8'h7f);
   endtask
endmodule

// File: rtl/fault_flag_byte.sv
// One byte of sticky fault flags with host write-zero clear.
// Assumes detector inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`include "fault_status_cfg.svh"
module fault_flag_byte
   import fault_status_pkg::*;
#(
   parameter fault_byte_t RESET_VAL = 8'h00,
   parameter fault_byte_t LIVE_MASK = 8'hff
)
(
   // Clock and control
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   // Detector events
   input  wire fault_byte_t detect,
   // Host write
   input  wire logic        wr_en,
   input  wire fault_byte_t wr_data,
   // Flag state
   output fault_byte_t      flags
);

   fault_byte_t flags_ff;
   wire fault_byte_t nxt_flags;

   // Per-bit sticky flag; a detect in the clear cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_bit
         assign nxt_flags[gi] = LIVE_MASK[gi] &
            (detect[gi] | (wr_en ? (wr_data[gi] & flags_ff[gi]) : flags_ff[gi]));
      end
   endgenerate

   // Writing one keeps state only, never creates a flag
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         flags_ff <= RESET_VAL;
      else if (clk_en)
         flags_ff <= nxt_flags;
   end

   assign flags = flags_ff;

endmodule

// File: rtl/fault_status_cfg.svh
// Register offsets, bit positions and reset values of the fault status bank.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef FAULT_STATUS_CFG_SVH
`define FAULT_STATUS_CFG_SVH

// Register addresses on the management port
`define ADDR_SUMMARY        8'hc0
`define ADDR_BUS_WARN       8'hd2
`define ADDR_AUX_FAULT      8'hd3
`define ADDR_REG_FAULT      8'hd4

// Reset values
`define RST_BUS_WARN        8'h00
`define RST_AUX_FAULT       8'h00
`define RST_REG_FAULT       8'h00

// Flags that exist in the regulator register
`define REG_FAULT_MASK      8'h31

// Summary register bit positions
`define SUM_BIT_BUS_WARN    0
`define SUM_BIT_AUX_FAULT   1
`define SUM_BIT_REG_FAULT   2
`define SUM_BIT_ALERT       7

// Power-on-reset flag position in the auxiliary register
`define AUX_BIT_POR         7

`endif

// File: rtl/fault_status_pkg.sv
// Types shared by the fault status bank.
// Assumes the cfg header carries all numeric constants.
package fault_status_pkg;
   typedef logic [7:0] fault_byte_t;
   typedef enum logic [1:0] {
      sel_none,
      sel_write,
      sel_read
   } access_kind_t;
endpackage

// File: rtl/fault_status_registers.sv
// Fault status bank: bus warnings, auxiliary supplies, regulator flags.
// Assumes a byte register port decoded by the management bus front end,
// detector strobes synchronous to sys_clk, and srst from power-on reset.
// Assumes the host services the power-on flag before clearing it, and
// that clk_en low pauses the register port along with the flags.
`timescale 1ns/1ps
`include "fault_status_cfg.svh"
module fault_status_registers
   import fault_status_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   // Register strobes
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   // Register address and write data
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   // Read answer
   output logic [7:0]       reg_rdata,
   output logic             reg_rvalid,
   // Conversion direction: 1 step-down, 0 step-up
   input  wire logic        step_down_mode,
   // Low bus warning detectors
   input  wire logic        low_voltage_bus_out_ov,
   input  wire logic        low_voltage_bus_out_uv,
   input  wire logic        low_voltage_bus_in_ov,
   input  wire logic        low_voltage_bus_in_uv,
   // High bus warning detectors
   input  wire logic        high_voltage_bus_out_ov,
   input  wire logic        high_voltage_bus_out_uv,
   input  wire logic        high_voltage_bus_in_ov,
   input  wire logic        high_voltage_bus_in_uv,
   // Auxiliary supply detectors
   input  wire logic        six_volt_aux_rail_ov,
   input  wire logic        six_volt_aux_rail_uv,
   input  wire logic        twelve_volt_driver_rail_ov,
   input  wire logic        twelve_volt_driver_rail_uv,
   input  wire logic        flyback_overcurrent,
   // Supply input, lockout and reset detectors
   input  wire logic        controller_supply_input_ov,
   input  wire logic        low_voltage_bus_supply_lockout,
   input  wire logic        power_on_reset_event,
   // Regulator detectors
   input  wire logic        driver_supply_not_good,
   input  wire logic        aux_regulator_output_ov,
   input  wire logic        aux_regulator_output_uv,
   // Alert
   output logic             alert_pin_n
);

   fault_byte_t bus_warn;
   fault_byte_t aux_fault;
   fault_byte_t reg_fault;
   fault_byte_t summary;
   wire fault_byte_t bus_detect;
   wire fault_byte_t aux_detect;
   wire fault_byte_t reg_detect;
   access_kind_t access_kind;

   logic [7:0] rdata_ff;
   logic       rvalid_ff;
   logic       alert_n_ff;
   logic       por_pend_ff;
   logic [7:0] nxt_rdata;

   // Access decode; write takes priority when both strobes are high
   assign access_kind = reg_wr ? sel_write : (reg_rd ? sel_read : sel_none);

   // Strobe qualifiers shared by the write enables and the read answer
   wire is_write = (access_kind == sel_write);
   wire is_read  = (access_kind == sel_read);

   // Address hits; every other address is unmapped
   wire hit_summary = (reg_addr == `ADDR_SUMMARY);
   wire hit_bus     = (reg_addr == `ADDR_BUS_WARN);
   wire hit_aux     = (reg_addr == `ADDR_AUX_FAULT);
   wire hit_reg     = (reg_addr == `ADDR_REG_FAULT);

   // Write enables; the summary byte is derived, so writes to it are dropped
   wire wr_bus = is_write & hit_bus;
   wire wr_aux = is_write & hit_aux;
   wire wr_reg = is_write & hit_reg;

   // Bus warnings qualified by direction; bits 0, 1, 6 and 7 are gated to step-down mode
   assign bus_detect[0] = low_voltage_bus_out_ov & step_down_mode;
   assign bus_detect[1] = low_voltage_bus_out_uv & step_down_mode;
   assign bus_detect[2] = low_voltage_bus_in_ov & ~step_down_mode;
   assign bus_detect[3] = low_voltage_bus_in_uv & ~step_down_mode;
   assign bus_detect[4] = high_voltage_bus_out_ov & ~step_down_mode;
   assign bus_detect[5] = high_voltage_bus_out_uv & ~step_down_mode;
   assign bus_detect[6] = high_voltage_bus_in_ov & step_down_mode;
   assign bus_detect[7] = high_voltage_bus_in_uv & step_down_mode;

   assign aux_detect[0] = six_volt_aux_rail_ov;
   assign aux_detect[1] = six_volt_aux_rail_uv;
   assign aux_detect[2] = twelve_volt_driver_rail_ov;
   assign aux_detect[3] = twelve_volt_driver_rail_uv;
   assign aux_detect[4] = flyback_overcurrent;
   assign aux_detect[5] = controller_supply_input_ov;
   assign aux_detect[6] = low_voltage_bus_supply_lockout;
   assign aux_detect[`AUX_BIT_POR] = power_on_reset_event | por_pend_ff;

   // regulator flag positions
   // Reserved positions are tied low here and masked in the flag byte too
   assign reg_detect[0]   = driver_supply_not_good;
   assign reg_detect[3:1] = 3'b000;
   assign reg_detect[4]   = aux_regulator_output_ov;
   assign reg_detect[5]   = aux_regulator_output_uv;
   assign reg_detect[7:6] = 2'b00;

   // Power-on reset itself must leave the flag set once reset releases
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         por_pend_ff <= 1'b1;
      else if (clk_en)
         por_pend_ff <= 1'b0;
   end

   fault_flag_byte #(
      .RESET_VAL (`RST_BUS_WARN),
      .LIVE_MASK (8'hff)
   ) u_bus_warn (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .detect  (bus_detect),
      .wr_en   (wr_bus),
      .wr_data (reg_wdata),
      .flags   (bus_warn)
   );

   fault_flag_byte #(
      .RESET_VAL (`RST_AUX_FAULT),
      .LIVE_MASK (8'hff)
   ) u_aux_fault (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .detect  (aux_detect),
      .wr_en   (wr_aux),
      .wr_data (reg_wdata),
      .flags   (aux_fault)
   );

   fault_flag_byte #(
      .RESET_VAL (`RST_REG_FAULT),
      .LIVE_MASK (`REG_FAULT_MASK)
   ) u_reg_fault (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .detect  (reg_detect),
      .wr_en   (wr_reg),
      .wr_data (reg_wdata),
      .flags   (reg_fault)
   );

   fault_summary u_summary (
      .bus_warn  (bus_warn),
      .aux_fault (aux_fault),
      .reg_fault (reg_fault),
      .summary   (summary)
   );

   // Read select as AND-OR of one-hot hits; unmapped addresses read zero
   wire fault_byte_t rd_summary = {8{hit_summary}} & summary;
   wire fault_byte_t rd_bus     = {8{hit_bus}} & bus_warn;
   wire fault_byte_t rd_aux     = {8{hit_aux}} & aux_fault;
   wire fault_byte_t rd_reg     = {8{hit_reg}} & reg_fault;
   assign nxt_rdata = rd_summary | rd_bus | rd_aux | rd_reg;

   // Read answer registered one cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         rvalid_ff <= is_read;
         if (is_read)
            rdata_ff <= nxt_rdata;
      end
   end

   // alert pin low on any fault
   wire nxt_alert_n = ~summary[`SUM_BIT_ALERT];

   // Registered so the pin cannot glitch while flags settle
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         alert_n_ff <= 1'b1;
      else if (clk_en)
         alert_n_ff <= nxt_alert_n;
   end

   assign reg_rdata   = rdata_ff;
   assign reg_rvalid  = rvalid_ff;
   assign alert_pin_n = alert_n_ff;

endmodule

// File: rtl/fault_summary.sv
// Summary byte: one bit per fault register plus global alert.
// Assumes the three flag bytes come straight from flops.
`timescale 1ns/1ps
`include "fault_status_cfg.svh"
module fault_summary
   import fault_status_pkg::*;
(
   // Flag bytes
   input  wire fault_byte_t bus_warn,
   input  wire fault_byte_t aux_fault,
   input  wire fault_byte_t reg_fault,
   // Summary
   output wire fault_byte_t summary
);

   wire any_bus = |bus_warn;
   wire any_aux = |aux_fault;
   wire any_reg = |reg_fault;

   // Registers beyond the third are not in this bank, read zero
   assign summary[`SUM_BIT_BUS_WARN]  = any_bus;
   assign summary[`SUM_BIT_AUX_FAULT] = any_aux;
   assign summary[`SUM_BIT_REG_FAULT] = any_reg;
   assign summary[6:3]                = 4'h0;
   assign summary[`SUM_BIT_ALERT]     = any_bus | any_aux | any_reg;

endmodule
